// >>> verilog/tmc_defines.svh
// Constants for the transceiver mode configuration block
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Character path widths
`define TMC_CHAR_W 12
`define TMC_WIDE_RAW_W 12
`define TMC_NARROW_RAW_W 10
`define TMC_WIDE_CODED_W 10
`define TMC_NARROW_CODED_W 8

// Transmit buffer shape
`define TMC_FIFO_DEPTH 16
`define TMC_FIFO_HALF 8

// Receive discard policy encodings
`define TMC_POL_KEEP_ALL 2'h0
`define TMC_POL_FLAG_FILL 2'h1
`define TMC_POL_DROP_FILL 2'h2
`define TMC_POL_DROP_BAD 2'h3

// Reference clock prescaler ratios
`define TMC_PRESCALE_UNITY 2'h1
`define TMC_PRESCALE_HALF 2'h2

`endif

// >>> verilog/tmc_pkg.sv
// Types for the transceiver mode configuration block
package tmc_pkg;

    typedef enum logic [1:0] {
        TMC_POL_KEEP_ALL = 2'h0,
        TMC_POL_FLAG_FILL = 2'h1,
        TMC_POL_DROP_FILL = 2'h2,
        TMC_POL_DROP_BAD = 2'h3
    } tmc_policy_t;

    typedef struct packed {
        logic tx_sel_q;
        logic [11:0] tx_hold_q;
        logic slot_q;
        logic [11:0] ser_char_q;
        logic ser_valid_q;
        logic [11:0] rx_data_q;
        logic rx_valid_q;
        logic rx_clk_q;
    } tmc_state_t;

endpackage

// >>> verilog/tmc_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_fifo #(
    parameter int WIDTH = `TMC_CHAR_W,
    parameter int DEPTH = `TMC_FIFO_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [AW:0] level_out
);

    // ==========================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_out = (cnt_q != DEPTH[AW:0]);
    assign out_valid_out = (cnt_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_q[rd_q];
    assign level_out = cnt_q;

    // Memory has no reset; only pointers and count carry control state
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// >>> verilog/tmc_config.sv
// Transceiver static mode configuration and host port logic
//
// Behaviour
// - Prescaler ratio follows the two range inputs only
// - Bypass, non-unity ratio: full flag toggles
// - Direct bus mode: enables, flags active low
// - Direct bus mode: data taken with enable
// - Cascade mode: enables/full/empty high, half-full low
// - Cascade mode: data taken cycle after enable
// - Bypass: transmit data synchronous to reference
// - Bypass: transmit flags synchronous to reference
// - Bypass: receive clock becomes recovered output
// - FIFOs on: writes and reads on clocks
// - Coding bypass: raw NRZ transmit, LSB first
// - Coding bypass: receive raw undecoded words
// - Coding on: 8B/10B encode and decode
// - Coding on: two-bit policy picks receive discard mode
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_config
    import tmc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic rate_range_select_in,
    input wire logic prescaler_range_select_in,
    input wire logic external_fifo_mode_in,
    input wire logic fifo_bypass_n_in,
    input wire logic coding_bypass_n_in,
    input wire logic character_width_select_in,
    input wire logic serial_loop_through_select_in,
    input wire logic [1:0] receive_discard_policy_in,
    input wire logic transmit_enable_in,
    input wire logic [11:0] tx_data_in,
    output logic transmit_full_flag_out,
    output logic tx_half_full_n_out,
    output logic tx_empty_flag_out,
    input wire logic ser_char_ready_in,
    output logic [11:0] ser_char_out,
    output logic ser_char_valid_out,
    output logic encode_enable_out,
    output logic [1:0] prescale_ratio_out,
    input wire logic rx_char_strobe_in,
    input wire logic [11:0] rx_char_in,
    input wire logic rx_fill_char_in,
    input wire logic rx_code_error_in,
    input wire logic receive_enable_in,
    output logic [11:0] rx_data_out,
    output logic rx_empty_flag_out,
    output logic decode_enable_out,
    output logic receive_side_clock_out,
    output logic receive_side_clock_oe_out,
    output logic config_error_out
);

    // ==========================================================
    // Mode decode
    logic bypass;
    logic cascade;
    logic coded;
    logic nonunity;
    logic ref_fast;
    logic tx_active;
    logic rx_active;
    logic [11:0] width_mask;
    tmc_policy_t policy;

    assign bypass = !fifo_bypass_n_in;
    assign cascade = external_fifo_mode_in;
    assign coded = coding_bypass_n_in;
    assign policy = tmc_policy_t'(receive_discard_policy_in);

    // Reference runs faster than characters in these settings
    assign ref_fast = prescaler_range_select_in ||
        !rate_range_select_in;
    assign nonunity = bypass && ref_fast;

    // Ratio is a pure function of static pins, so no state
    assign prescale_ratio_out = ref_fast ? `TMC_PRESCALE_HALF :
        `TMC_PRESCALE_UNITY;

    // Enable polarity flips with the cascade option
    assign tx_active = cascade ? transmit_enable_in :
        !transmit_enable_in;
    assign rx_active = cascade ? receive_enable_in :
        !receive_enable_in;

    assign encode_enable_out = coded;
    assign decode_enable_out = coded;

    // ==========================================================
    // Character width
    logic [3:0] char_bits;

    // Usable character bits per coding and width choice
    always_comb begin
        if (coded) begin
            if (character_width_select_in) begin
                char_bits = 4'(`TMC_NARROW_CODED_W);
            end else begin
                char_bits = 4'(`TMC_WIDE_CODED_W);
            end
        end else begin
            if (character_width_select_in) begin
                char_bits = 4'(`TMC_NARROW_RAW_W);
            end else begin
                char_bits = 4'(`TMC_WIDE_RAW_W);
            end
        end
    end

    // One compare per bit keeps the mask in step with the widths
    for (genvar i = 0; i < `TMC_CHAR_W; i++) begin : g_mask
        assign width_mask[i] = (4'(i) < char_bits);
    end

    // ==========================================================
    // Host wiring checks
    logic width_misuse;
    logic loop_misuse;

    // Misuse indicator; the device cannot correct host wiring
    assign width_misuse = bypass && coded &&
        !character_width_select_in;
    assign loop_misuse = bypass && serial_loop_through_select_in;
    assign config_error_out = width_misuse || loop_misuse;

    // ==========================================================
    // Transmit buffer
    tmc_state_t s_q;
    tmc_state_t s_d;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [11:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [11:0] fifo_out_data;
    logic [4:0] fifo_level;
    logic take_now;
    logic full_active;
    logic half_active;
    logic empty_active;

    // Host may only write in accepting character slots
    always_comb begin
        if (cascade) begin
            take_now = s_q.tx_sel_q;
            fifo_in_data = s_q.tx_hold_q;
        end else begin
            take_now = tx_active;
            fifo_in_data = tx_data_in;
        end
    end

    // All host writes use the reference clock; a separate write
    // clock is not modelled, so both FIFO modes share one domain
    assign fifo_in_valid = take_now && s_q.slot_q;
    assign fifo_out_ready = ser_char_ready_in;

    tmc_fifo #(
        .WIDTH(`TMC_CHAR_W),
        .DEPTH(`TMC_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data),
        .level_out(fifo_level)
    );

    // ==========================================================
    // Transmit flags
    always_comb begin
        if (nonunity) begin
            full_active = !s_q.slot_q || !fifo_in_ready;
        end else begin
            full_active = !fifo_in_ready;
        end
        half_active = (fifo_level >= 5'(`TMC_FIFO_HALF));
        empty_active = !fifo_out_valid;
    end

    assign transmit_full_flag_out = cascade ? full_active :
        !full_active;
    assign tx_empty_flag_out = cascade ? empty_active :
        !empty_active;
    assign tx_half_full_n_out = !half_active;

    // ==========================================================
    // Receive qualifiers
    logic rx_read;
    logic rx_expire;
    logic ser_take;
    logic rx_drop;
    logic rx_mark;

    // Reads only exist while the receive buffer is in the path
    assign rx_read = !bypass && rx_active;
    // Without a buffer a word is only good until the next one
    assign rx_expire = bypass && rx_char_strobe_in;
    assign ser_take = fifo_out_valid && ser_char_ready_in;

    // Discard policy acts only on decoded traffic
    always_comb begin
        rx_drop = 1'b0;
        rx_mark = 1'b0;
        if (coded) begin
            case (policy)
                TMC_POL_KEEP_ALL: begin
                    rx_drop = 1'b0;
                end
                TMC_POL_FLAG_FILL: begin
                    rx_mark = rx_fill_char_in;
                end
                TMC_POL_DROP_FILL: begin
                    rx_drop = rx_fill_char_in;
                end
                TMC_POL_DROP_BAD: begin
                    rx_drop = rx_fill_char_in ||
                        rx_code_error_in;
                end
                default: begin
                    rx_drop = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;

        // Cascade mode latches the data one cycle after selection
        s_d.tx_sel_q = tx_active;
        s_d.tx_hold_q = tx_data_in;

        // Slot marker halves the reference rate when non-unity
        if (nonunity) begin
            s_d.slot_q = !s_q.slot_q;
        end else begin
            s_d.slot_q = 1'b1;
        end

        // Serialiser side: one registered character per request
        s_d.ser_valid_q = 1'b0;
        if (ser_take) begin
            s_d.ser_char_q = fifo_out_data & width_mask;
            s_d.ser_valid_q = 1'b1;
        end

        // Host read consumes the word; FIFO mode only
        if (rx_read) begin
            s_d.rx_valid_q = 1'b0;
        end
        // Bypass valid lasts one recovered character
        if (rx_expire) begin
            s_d.rx_valid_q = 1'b0;
        end
        // A new character wins over a read in the same cycle
        if (rx_char_strobe_in) begin
            s_d.rx_clk_q = !s_q.rx_clk_q;
            if (!rx_drop) begin
                s_d.rx_data_q = rx_char_in & width_mask;
                s_d.rx_valid_q = !rx_mark;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.slot_q <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Receive outputs
    assign rx_data_out = s_q.rx_data_q;
    assign rx_empty_flag_out = cascade ? !s_q.rx_valid_q :
        s_q.rx_valid_q;
    // Recovered clock only leaves the pin in bypass mode
    assign receive_side_clock_out = s_q.rx_clk_q;
    assign receive_side_clock_oe_out = bypass;
    assign ser_char_out = s_q.ser_char_q;
    assign ser_char_valid_out = s_q.ser_valid_q;

endmodule

// >>> sim/tmc_host_model.sv
// Host bus partner: direct bus controller or cascaded external FIFO
`timescale 1ns/1ps
module tmc_host_model (
    input wire logic ext_in,
    input wire logic go_in,
    input wire logic [11:0] word_in,
    output logic en_out,
    output logic [11:0] data_out
);
    // ====================
    // Drive
    // Cascade: the FIFO empty flag sits on the enable, active high
    assign en_out = ext_in ? go_in : !go_in;
    // Idle bus shows the inverted word so stale data never matches
    assign data_out = go_in ? word_in : ~word_in;
endmodule

// >>> sim/tmc_config_checker.sv
// Concurrent property checker for the mode configuration block
`timescale 1ns/1ps
module tmc_config_checker (
    input wire logic ref_clk_in, rst_n_in, rate_range_select_in,
    input wire logic prescaler_range_select_in, external_fifo_mode_in,
    input wire logic fifo_bypass_n_in, coding_bypass_n_in,
    input wire logic transmit_enable_in, transmit_full_flag_out,
    input wire logic tx_half_full_n_out, tx_empty_flag_out,
    input wire logic ser_char_ready_in, ser_char_valid_out,
    input wire logic encode_enable_out, decode_enable_out,
    input wire logic rx_char_strobe_in, rx_fill_char_in,
    input wire logic rx_empty_flag_out, receive_side_clock_out,
    input wire logic receive_side_clock_oe_out,
    input wire logic [1:0] receive_discard_policy_in, prescale_ratio_out,
    input wire logic [11:0] rx_char_in, rx_data_out
);
    // ====================
    // Helpers
    logic ext, on, slow, mt, pop;
    assign ext = external_fifo_mode_in;
    assign on = fifo_bypass_n_in;
    assign slow = !on && (prescaler_range_select_in || !rate_range_select_in);
    assign mt = tx_empty_flag_out == ext;
    assign pop = ser_char_ready_in && !mt;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_cas_wr;
        ext && on && transmit_enable_in && mt && !transmit_full_flag_out;
    endsequence
    sequence s_land;
        mt ##1 !mt;
    endsequence
    // ====================
    // Properties
    a_coding_follows: assert property (
        encode_enable_out == coding_bypass_n_in &&
        decode_enable_out == coding_bypass_n_in)
        else $error("coding enables wrong");
    a_prescale_pick: assert property (prescale_ratio_out ==
        (slow || (on && (prescaler_range_select_in || !rate_range_select_in))
        ? 2'h2 : 2'h1)) else $error("prescale wrong");
    a_rx_clk_dir: assert property (receive_side_clock_oe_out == !on)
        else $error("rx clock direction wrong");
    a_rx_clk_tog: assert property (rx_char_strobe_in |=>
        receive_side_clock_out != $past(receive_side_clock_out))
        else $error("rx clock did not toggle");
    a_slot_toggle: assert property (slow && tx_half_full_n_out |=>
        transmit_full_flag_out != $past(transmit_full_flag_out))
        else $error("full flag did not toggle");
    a_empty_polar: assert property (mt |-> tx_half_full_n_out)
        else $error("empty with half full");
    a_full_polar: assert property (on && transmit_full_flag_out == ext |->
        !mt && !tx_half_full_n_out) else $error("full flag polarity");
    a_direct_take: assert property (!ext && on && !transmit_enable_in && mt
        && transmit_full_flag_out |=> !mt) else $error("direct write late");
    a_cascade_take: assert property (s_cas_wr ##0
        !$past(transmit_enable_in) |=> s_land)
        else $error("cascade write timing");
    a_drain_pulse: assert property (ser_char_valid_out == $past(pop))
        else $error("drain pulse wrong");
    a_rx_keep: assert property (rx_char_strobe_in &&
        receive_discard_policy_in == 2'h0 |=> rx_empty_flag_out == !ext)
        else $error("rx word not flagged valid");
    a_rx_drop: assert property (coding_bypass_n_in && rx_char_strobe_in &&
        receive_discard_policy_in == 2'h2 && rx_fill_char_in
        |=> $stable(rx_data_out)) else $error("fill char not dropped");
endmodule
bind tmc_config tmc_config_checker u_chk (.*);

// >>> sim/tmc_config_tb.sv
// Self-checking bench for the mode configuration block
`timescale 1ns/1ps
module tmc_config_tb;
    logic ref_clk_in = 0, rst_n_in = 0, rate_range_select_in;
    logic prescaler_range_select_in, external_fifo_mode_in, fifo_bypass_n_in;
    logic coding_bypass_n_in, character_width_select_in, ser_char_ready_in;
    logic serial_loop_through_select_in, transmit_enable_in, rx_code_error_in;
    logic transmit_full_flag_out, tx_half_full_n_out, tx_empty_flag_out;
    logic ser_char_valid_out, encode_enable_out, rx_char_strobe_in;
    logic rx_fill_char_in, receive_enable_in, rx_empty_flag_out;
    logic decode_enable_out, receive_side_clock_out, receive_side_clock_oe_out;
    logic config_error_out, go, slot, pend, ev, full;
    logic nu, dr, rv, rc, ex;
    logic [1:0] receive_discard_policy_in, prescale_ratio_out;
    logic [11:0] tx_data_in, ser_char_out, rx_char_in, rx_data_out;
    logic [11:0] w, pw, ew, rx_e, msk;
    logic [31:0] r;
    logic [11:0] q[$];
    int seed = 99, mismatches = 0, n_checks = 0, mb;
    tmc_config dut (.*);
    tmc_host_model host (.ext_in(external_fifo_mode_in), .go_in(go),
        .word_in(w), .en_out(transmit_enable_in), .data_out(tx_data_in));
    initial forever #4 ref_clk_in = !ref_clk_in;
    // ====================
    // Checking
    task automatic chk(input string s, input logic [11:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(input string s, input logic e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %b seen %b", s, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Reference model of the transmit stage and receive register
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q.delete();
            slot = 1;
            pend = 0;
            ev = 0;
            rx_e = 0;
            rv = 0;
            rc = 0;
        end else begin
            ex = external_fifo_mode_in;
            nu = !fifo_bypass_n_in &&
                (prescaler_range_select_in || !rate_range_select_in);
            full = q.size() >= 16;
            chk_bit("ser_valid", ev, ser_char_valid_out);
            if (ev) chk("ser_char", ew, ser_char_out);
            chk("rx_data", rx_e, rx_data_out);
            chk_bit("tx_full", ex == ((nu && !slot) || full),
                transmit_full_flag_out);
            chk_bit("tx_empty", ex == (q.size() == 0),
                tx_empty_flag_out);
            chk_bit("tx_half_n", q.size() < 8, tx_half_full_n_out);
            chk_bit("rx_empty", ex ^ rv, rx_empty_flag_out);
            chk_bit("rx_clk", rc, receive_side_clock_out);
            ev = ser_char_ready_in && q.size() > 0;
            if (ev) ew = q.pop_front() & msk;
            if ((ex ? pend : go) && slot && !full)
                q.push_back(ex ? pw : w);
            pend = go;
            pw = w;
            slot = !(slot && nu);
            dr = coding_bypass_n_in &&
                ((receive_discard_policy_in == 2'h2 && rx_fill_char_in) ||
                (receive_discard_policy_in == 2'h3 &&
                (rx_fill_char_in || rx_code_error_in)));
            // Buffered reads clear the word; unbuffered, each strobe does
            if (fifo_bypass_n_in ? ex == receive_enable_in :
                rx_char_strobe_in) rv = 0;
            if (rx_char_strobe_in && !dr) begin
                rx_e = rx_char_in & msk;
                rv = !(coding_bypass_n_in && rx_fill_char_in &&
                    receive_discard_policy_in == 2'h1);
            end
            if (rx_char_strobe_in) rc = !rc;
        end
    end
    // Watchdog sized well above twelve tests of 210 cycles
    initial begin
        repeat (4000) @(posedge ref_clk_in);
        mismatches++;
        close_out();
    end
    // ====================
    // Stimulus
    initial begin
        {go, w, ser_char_ready_in, rx_char_strobe_in, rx_char_in} = 0;
        {rx_fill_char_in, rx_code_error_in, receive_enable_in} = 0;
        for (int t = 0; t < 12; t++) begin
            rst_n_in = 0;
            r = $random(seed);
            mb = 50 + r[7:0] % 151;
            rate_range_select_in = mb > 100;
            // First four tests: bypass in both bus modes, prescaler range select low and high
            prescaler_range_select_in = t < 4 ? t[0] : r[8];
            external_fifo_mode_in = t < 4 ? t[1] : r[9];
            fifo_bypass_n_in = t < 4 ? 1'b0 : r[10];
            coding_bypass_n_in = r[11];
            character_width_select_in = r[12] |
                (!fifo_bypass_n_in & r[11]);
            serial_loop_through_select_in = fifo_bypass_n_in & r[13];
            receive_discard_policy_in = t[1:0];
            msk = coding_bypass_n_in ?
                (character_width_select_in ? 12'h0FF : 12'h3FF) :
                (character_width_select_in ? 12'h3FF : 12'hFFF);
            repeat (10) @(posedge ref_clk_in);
            #1 rst_n_in = 1;
            chk("config_err", 12'h000, {11'h000, config_error_out});
            chk("prescale", (prescaler_range_select_in ||
                !rate_range_select_in) ? 12'h002 : 12'h001,
                {10'h000, prescale_ratio_out});
            chk("rx_clk_oe", {11'h000, !fifo_bypass_n_in},
                {11'h000, receive_side_clock_oe_out});
            repeat (200) begin
                @(posedge ref_clk_in);
                #1 r = $random(seed);
                go = r[0];
                w = r[12:1];
                // Odd tests drain slowly so the buffer fills and refuses
                ser_char_ready_in = t[0] ? &r[14:13] : r[13];
                rx_char_strobe_in = r[15];
                rx_char_in = r[27:16];
                {rx_fill_char_in, rx_code_error_in, receive_enable_in} = r[30:28];
            end
            $display("test %0d done", t);
        end
        close_out();
    end
endmodule
